// [hdl/bus_master_dma.sv]
// Two-channel bus-master DMA: video/graphics channel and circular command channel
//
// Functional notes
// - Video and command channels run independently, either or both active.
// - Device masters the host bus for both channels itself.
// - Direction bit 0 moves memory to local port FIFO; 1 moves video memory out.
// - Video system address comes from start register bits 31-2.
// - Video channel moves length field plus one doublewords.
// - Writing video enable 1 starts the channel; 0 keeps it off.
// - Device clears video enable itself when the transfer ends.
// - Buffer size bit picks 4 KByte (0) or 64 KByte (1) ring.
// - 4K fetch address is base 31-12, read pointer 11-2, two zeros.
// - 64K fetch address is base 31-16, read pointer 15-2, two zeros.
// - Device advances read pointer; it always names next doubleword.
// - Command enable bit turns command fetching on and off.
// - Fetched command doublewords go to the drawing engine.
// - Video reads move width field plus one quadwords per line, then add stride.
// - Done flags set when video or command transfers complete.
//
// Register access over APB was chosen for this implementation.
`timescale 1ns/1ns
`default_nettype none
module bus_master_dma (
    input  wire logic                  pclk,
    input  wire logic                  presetn,
    input  wire logic                  psel,
    input  wire logic                  penable,
    input  wire logic                  pwrite,
    input  wire logic [15:0]           paddr,
    input  wire logic [31:0]           pwdata,
    output logic [31:0]                prdata,
    output logic                       pready,
    output logic                       pslverr,
    output logic                       host_req_valid,
    output dma_pkg::host_req_t         host_req,
    input  wire logic                  host_ack,
    input  wire logic [31:0]           host_rdata,
    output logic                       lpb_valid,
    output logic [31:0]                lpb_data,
    input  wire logic                  lpb_ready,
    output logic                       vmem_rd_req,
    output logic [31:0]                vmem_rd_addr,
    input  wire logic                  vmem_rd_ack,
    input  wire logic [63:0]           vmem_rd_data,
    output logic                       cmd_valid,
    output logic [31:0]                cmd_data,
    input  wire logic                  cmd_ready
);
    // ==============================
    // Register state
    logic [31:1] vstart_q;
    logic [21:0] vlen_q;
    logic        ven_q;
    logic [31:12] cbase_q;
    logic        bs_q;
    logic [15:2] cwp_q;
    logic [15:2] wp_eff_q;
    logic        wpu_q;
    logic [15:2] crp_q;
    logic        cen_q;
    logic [31:3] rbase_q;
    logic [8:0]  stride_q;
    logic [8:0]  width_q;
    logic        read_dma_pointer_reset_q;
    logic        hd_done_q;
    logic        cd_done_q;
    logic [31:0] prdata_q;
    logic        pready_q;
    logic        pslverr_q;

    // ==============================
    // Channel state
    dma_pkg::vid_state_t vst_q;
    dma_pkg::vid_state_t vst_d;
    dma_pkg::cmd_state_t cst_q;
    logic [31:2] vsys_q;
    logic [21:0] rem_q;
    logic [31:0] vaddr_q;
    logic [8:0]  qw_cnt_q;
    logic [63:0] qw_q;
    logic [31:0] lpb_data_q;
    logic        lpb_valid_q;
    logic        vmem_req_q;
    logic [31:0] cmd_data_q;
    logic        cmd_valid_q;
    dma_pkg::host_req_t vid_req;
    dma_pkg::host_req_t cmd_req;
    logic [1:0]  gnt_done;

    // ==============================
    // APB decode: one wait state, write takes effect with pready high
    logic access, wr_en, rd_cap, map_hit;
    logic hit_rbase, hit_rstr, hit_stat, hit_adv, hit_vst, hit_vlen, hit_ven;
    logic hit_cbase, hit_cwp, hit_crp, hit_cen;
    assign access    = psel & penable;
    assign wr_en     = access & pwrite & pready_q;
    assign rd_cap    = access & ~pready_q;
    assign hit_rbase = (paddr == dma_pkg::OFS_RD_BASE);
    assign hit_rstr  = (paddr == dma_pkg::OFS_RD_STRIDE);
    assign hit_stat  = (paddr == dma_pkg::OFS_SUB_STAT);
    assign hit_adv   = (paddr == dma_pkg::OFS_ADV_CTRL);
    assign hit_vst   = (paddr == dma_pkg::OFS_VID_START);
    assign hit_vlen  = (paddr == dma_pkg::OFS_VID_LEN);
    assign hit_ven   = (paddr == dma_pkg::OFS_VID_EN);
    assign hit_cbase = (paddr == dma_pkg::OFS_CMD_BASE);
    assign hit_cwp   = (paddr == dma_pkg::OFS_CMD_WP);
    assign hit_crp   = (paddr == dma_pkg::OFS_CMD_RP);
    assign hit_cen   = (paddr == dma_pkg::OFS_CMD_EN);
    assign map_hit   = hit_rbase | hit_rstr | hit_stat | hit_adv | hit_vst | hit_vlen | hit_ven
                     | hit_cbase | hit_cwp | hit_crp | hit_cen;

    // Read mux; reserved bits read as zero
    logic [31:0] rd_mux;
    always_comb begin
        rd_mux = dma_pkg::RST_WORD;
        if (hit_rbase)      rd_mux = {rbase_q, 3'b000};
        else if (hit_rstr)  rd_mux = {4'h0, width_q, 7'h00, stride_q, 3'b000};
        else if (hit_stat)  rd_mux = {26'h0, cd_done_q, hd_done_q, 4'h0};
        else if (hit_adv)   rd_mux = {30'h0, read_dma_pointer_reset_q, 1'b0};
        else if (hit_vst)   rd_mux = {vstart_q, 1'b0};
        else if (hit_vlen)  rd_mux = {8'h00, vlen_q, 2'b00};
        else if (hit_ven)   rd_mux = {31'h0, ven_q};
        else if (hit_cbase) rd_mux = {cbase_q, 10'h000, bs_q, 1'b0};
        else if (hit_cwp)   rd_mux = {15'h0, wpu_q, cwp_q, 2'b00};
        else if (hit_crp)   rd_mux = {16'h0, crp_q, 2'b00};
        else if (hit_cen)   rd_mux = {31'h0, cen_q};
    end

    // Bus answer registers; unmapped addresses answer with pslverr
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_q  <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q  <= dma_pkg::RST_WORD;
        end else begin
            pready_q  <= rd_cap;
            pslverr_q <= rd_cap & ~map_hit;
            if (rd_cap && !pwrite) prdata_q <= rd_mux;
        end
    end

    // ==============================
    // Plain configuration registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            vstart_q <= '0;
            vlen_q   <= '0;
            cbase_q  <= '0;
            bs_q     <= 1'b0;
            cwp_q    <= '0;
            cen_q    <= 1'b0;
            rbase_q  <= '0;
            stride_q <= '0;
            width_q  <= '0;
            read_dma_pointer_reset_q <= 1'b0;
        end else if (wr_en) begin
            if (hit_vst)   vstart_q <= pwdata[31:1];
            if (hit_vlen)  vlen_q   <= pwdata[23:2];
            if (hit_cbase) cbase_q  <= pwdata[31:12];
            if (hit_cbase) bs_q     <= pwdata[dma_pkg::BS_BIT];
            if (hit_cwp)   cwp_q    <= pwdata[15:2];
            if (hit_cen)   cen_q    <= pwdata[dma_pkg::EN_BIT];
            if (hit_rbase) rbase_q  <= pwdata[31:3];
            if (hit_rstr)  stride_q <= pwdata[11:3];
            if (hit_rstr)  width_q  <= pwdata[27:19];
            if (hit_adv)   read_dma_pointer_reset_q <= pwdata[dma_pkg::READ_DMA_POINTER_RESET_BIT];
        end
    end

    // Updated flag is consumed one cycle later, so a stale pointer is never compared
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wpu_q    <= 1'b0;
            wp_eff_q <= '0;
        end else begin
            wpu_q <= wr_en & hit_cwp & pwdata[dma_pkg::WPU_BIT];
            if (wpu_q) wp_eff_q <= cwp_q;
        end
    end

    // ==============================
    // Enable and done flags: done set wins over software clear; enable write wins over completion clear
    logic v_finish, c_drained, ven_wr;
    assign ven_wr = wr_en & hit_ven;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ven_q     <= 1'b0;
            hd_done_q <= 1'b0;
            cd_done_q <= 1'b0;
        end else begin
            if (ven_wr)        ven_q <= pwdata[dma_pkg::EN_BIT];
            else if (v_finish) ven_q <= 1'b0;
            hd_done_q <= v_finish  | (hd_done_q & ~(wr_en & hit_stat & pwdata[dma_pkg::HD_DONE_BIT]));
            cd_done_q <= c_drained | (cd_done_q & ~(wr_en & hit_stat & pwdata[dma_pkg::CD_DONE_BIT]));
        end
    end

    // ==============================
    // Video channel
    logic vid_done, last_dw, line_end;
    assign vid_done = gnt_done[0];
    assign last_dw  = (rem_q == 22'h0);
    assign line_end = (qw_cnt_q == width_q);
    assign v_finish = (vst_q == dma_pkg::V_PUSH && lpb_valid_q && lpb_ready && last_dw)
                    | ((vst_q == dma_pkg::V_WLO || vst_q == dma_pkg::V_WHI) && vid_done && last_dw);
    assign vid_req.write = (vst_q != dma_pkg::V_SRD);
    assign vid_req.addr  = {vsys_q, 2'b00};
    assign vid_req.wdata = (vst_q == dma_pkg::V_WHI) ? qw_q[63:32] : qw_q[31:0];

    // Next state of the video sequencer
    always_comb begin
        vst_d = vst_q;
        case (vst_q)
            dma_pkg::V_IDLE: if (ven_q) vst_d = vstart_q[dma_pkg::DIR_BIT] ? dma_pkg::V_VRD : dma_pkg::V_SRD;
            dma_pkg::V_SRD:  if (vid_done) vst_d = dma_pkg::V_PUSH;
            dma_pkg::V_PUSH: if (lpb_valid_q && lpb_ready) vst_d = last_dw ? dma_pkg::V_IDLE : dma_pkg::V_SRD;
            dma_pkg::V_VRD:  if (vmem_rd_ack) vst_d = dma_pkg::V_WLO;
            dma_pkg::V_WLO:  if (vid_done) vst_d = last_dw ? dma_pkg::V_IDLE : dma_pkg::V_WHI;
            dma_pkg::V_WHI:  if (vid_done) vst_d = last_dw ? dma_pkg::V_IDLE : dma_pkg::V_VRD;
            default:         vst_d = dma_pkg::V_IDLE;
        endcase
    end

    // Counting and addressing; each moved doubleword but the last steps the system address
    logic dw_moved;
    assign dw_moved = (vst_q == dma_pkg::V_PUSH && lpb_valid_q && lpb_ready)
                    | ((vst_q == dma_pkg::V_WLO || vst_q == dma_pkg::V_WHI) && vid_done);
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            vst_q  <= dma_pkg::V_IDLE;
            vsys_q <= '0;
            rem_q  <= '0;
        end else begin
            vst_q <= vst_d;
            if (vst_q == dma_pkg::V_IDLE && ven_q) begin
                vsys_q <= vstart_q[31:2];
                rem_q  <= vlen_q;
            end else if (dw_moved && !last_dw) begin
                vsys_q <= vsys_q + 30'h1;
                rem_q  <= rem_q - 22'h1;
            end
        end
    end

    // Local port output holds its word until taken
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            lpb_valid_q <= 1'b0;
            lpb_data_q  <= dma_pkg::RST_WORD;
        end else if (vst_q == dma_pkg::V_SRD && vid_done) begin
            lpb_valid_q <= 1'b1;
            lpb_data_q  <= host_rdata;
        end else if (lpb_ready) begin
            lpb_valid_q <= 1'b0;
        end
    end

    // Video memory line walker; pointer reset returns it to the read base
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            vmem_req_q <= 1'b0;
            vaddr_q    <= dma_pkg::RST_WORD;
            qw_cnt_q   <= '0;
            qw_q       <= '0;
        end else begin
            vmem_req_q <= (vst_d == dma_pkg::V_VRD);
            if (read_dma_pointer_reset_q) begin
                vaddr_q  <= {rbase_q, 3'b000};
                qw_cnt_q <= '0;
            end else if (vst_q == dma_pkg::V_VRD && vmem_rd_ack) begin
                qw_q <= vmem_rd_data;
                if (line_end) begin
                    vaddr_q  <= vaddr_q + dma_pkg::QW_STEP + {20'h0, stride_q, 3'b000};
                    qw_cnt_q <= '0;
                end else begin
                    vaddr_q  <= vaddr_q + dma_pkg::QW_STEP;
                    qw_cnt_q <= qw_cnt_q + 9'h1;
                end
            end
        end
    end

    // ==============================
    // Command channel, independent of the video sequencer
    logic [15:2] crp_next;
    logic        ptr_eq, cmd_take, crp_wr;
    assign crp_next = bs_q ? crp_q + 14'h1 : {crp_q[15:12], crp_q[11:2] + 10'h1};
    assign ptr_eq   = bs_q ? (crp_q == wp_eff_q) : (crp_q[11:2] == wp_eff_q[11:2]);
    assign cmd_take = (cst_q == dma_pkg::C_DELIVER) && cmd_valid_q && cmd_ready;
    assign crp_wr   = wr_en & hit_crp;
    assign c_drained = cmd_take & (bs_q ? (crp_next == wp_eff_q) : (crp_next[11:2] == wp_eff_q[11:2]));
    assign cmd_req.write = 1'b0;
    assign cmd_req.wdata = dma_pkg::RST_WORD;
    assign cmd_req.addr  = bs_q ? {cbase_q[31:16], crp_q[15:2], 2'b00}
                                : {cbase_q[31:12], crp_q[11:2], 2'b00};

    // Fetch, hand over, advance; a software pointer write overrides the advance
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cst_q       <= dma_pkg::C_IDLE;
            crp_q       <= '0;
            cmd_valid_q <= 1'b0;
            cmd_data_q  <= dma_pkg::RST_WORD;
        end else begin
            if (crp_wr)        crp_q <= pwdata[15:2];
            else if (cmd_take) crp_q <= crp_next;
            case (cst_q)
                dma_pkg::C_IDLE: if (cen_q && !ptr_eq) cst_q <= dma_pkg::C_FETCH;
                dma_pkg::C_FETCH: if (gnt_done[1]) begin
                    cmd_data_q  <= host_rdata;
                    cmd_valid_q <= 1'b1;
                    cst_q       <= dma_pkg::C_DELIVER;
                end
                dma_pkg::C_DELIVER: if (cmd_take) begin
                    cmd_valid_q <= 1'b0;
                    cst_q       <= dma_pkg::C_IDLE;
                end
                default: cst_q <= dma_pkg::C_IDLE;
            endcase
        end
    end

    // ==============================
    // Shared host bus master port
    logic [1:0] req_valid;
    assign req_valid = {cst_q == dma_pkg::C_FETCH,
                        vst_q == dma_pkg::V_SRD || vst_q == dma_pkg::V_WLO || vst_q == dma_pkg::V_WHI};
    host_arb u_arb (
        .pclk           (pclk),
        .presetn        (presetn),
        .req_valid      (req_valid),
        .req_vid        (vid_req),
        .req_cmd        (cmd_req),
        .host_ack       (host_ack),
        .host_req_valid (host_req_valid),
        .host_req       (host_req),
        .done           (gnt_done)
    );

    assign prdata       = prdata_q;
    assign pready       = pready_q;
    assign pslverr      = pslverr_q;
    assign lpb_valid    = lpb_valid_q;
    assign lpb_data     = lpb_data_q;
    assign vmem_rd_req  = vmem_req_q;
    assign vmem_rd_addr = vaddr_q;
    assign cmd_valid    = cmd_valid_q;
    assign cmd_data     = cmd_data_q;

    // ==============================
    // Checks
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    AST_VEN_CLR: assert property (v_finish && !ven_wr |=> !ven_q)
        else $error("video enable not cleared at completion");
    AST_HD_DONE: assert property (v_finish |=> hd_done_q)
        else $error("host done flag missing");
    AST_DIR0: assert property (vst_q == dma_pkg::V_IDLE && ven_q && !vstart_q[1] |=> vst_q == dma_pkg::V_SRD)
        else $error("direction 0 did not read system memory");
    AST_LEN: assert property (vst_q == dma_pkg::V_IDLE && ven_q |=> rem_q == $past(vlen_q))
        else $error("length not loaded");
    AST_ADDR4K: assert property (host_req_valid && !host_req.write && cst_q == dma_pkg::C_FETCH && !bs_q
        && !req_valid[0] |-> host_req.addr == {cbase_q, crp_q[11:2], 2'b00})
        else $error("4K fetch address wrong");
    AST_NO_FETCH_EQ: assert property (cst_q == dma_pkg::C_IDLE && ptr_eq |=> cst_q != dma_pkg::C_FETCH)
        else $error("fetch with equal pointers");
    AST_RP_ADV: assert property (cmd_take && !crp_wr |=> crp_q == $past(crp_next))
        else $error("read pointer did not advance");
    AST_CMD_OFF: assert property (!cen_q && cst_q == dma_pkg::C_IDLE |=> cst_q == dma_pkg::C_IDLE)
        else $error("command fetch while disabled");
    AST_LPB_HOLD: assert property (lpb_valid_q && !lpb_ready |=> lpb_valid_q && $stable(lpb_data_q))
        else $error("local port word dropped");
    AST_APB_WAIT: assert property (psel && penable && !pready |=> pready)
        else $error("bus answer late");
endmodule : bus_master_dma
`default_nettype wire

// [hdl/host_arb.sv]
// Round-robin owner of the single host bus master port shared by both channels
`timescale 1ns/1ns
`default_nettype none
module host_arb (
    input  wire logic                  pclk,
    input  wire logic                  presetn,
    input  wire logic [1:0]            req_valid,
    input  wire dma_pkg::host_req_t    req_vid,
    input  wire dma_pkg::host_req_t    req_cmd,
    input  wire logic                  host_ack,
    output logic                       host_req_valid,
    output dma_pkg::host_req_t         host_req,
    output logic [1:0]                 done
);
    logic busy_q;
    logic owner_q;
    logic last_q;
    logic pick;

    // Alternate when both ask, so neither channel starves the other
    assign pick = (req_valid == 2'b11) ? ~last_q : req_valid[1];
    assign done = {host_ack & busy_q & owner_q, host_ack & busy_q & ~owner_q};

    // One transaction outstanding; request held until the bus answers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            busy_q         <= 1'b0;
            owner_q        <= 1'b0;
            last_q         <= 1'b0;
            host_req_valid <= 1'b0;
            host_req       <= '0;
        end else if (busy_q) begin
            if (host_ack) begin
                busy_q         <= 1'b0;
                host_req_valid <= 1'b0;
                last_q         <= owner_q;
            end
        end else if (|req_valid) begin
            busy_q         <= 1'b1;
            owner_q        <= pick;
            host_req_valid <= 1'b1;
            host_req       <= pick ? req_cmd : req_vid;
        end
    end

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    AST_ARB_HOLD: assert property (host_req_valid && !host_ack |=> host_req_valid && $stable(host_req))
        else $error("host request changed before answer");
endmodule : host_arb
`default_nettype wire

// [inc/dma_pkg.sv]
// Register map, field layout and shared types of the two-channel bus-master DMA unit
package dma_pkg;
    // ==============================
    // Register byte offsets
    localparam logic [15:0] OFS_RD_BASE   = 16'h8220;
    localparam logic [15:0] OFS_RD_STRIDE = 16'h8224;
    localparam logic [15:0] OFS_SUB_STAT  = 16'h8504;
    localparam logic [15:0] OFS_ADV_CTRL  = 16'h850c;
    localparam logic [15:0] OFS_VID_START = 16'h8580;
    localparam logic [15:0] OFS_VID_LEN   = 16'h8584;
    localparam logic [15:0] OFS_VID_EN    = 16'h8588;
    localparam logic [15:0] OFS_CMD_BASE  = 16'h8590;
    localparam logic [15:0] OFS_CMD_WP    = 16'h8594;
    localparam logic [15:0] OFS_CMD_RP    = 16'h8598;
    localparam logic [15:0] OFS_CMD_EN    = 16'h859c;
    // ==============================
    // Field positions
    localparam int EN_BIT      = 0;
    localparam int DIR_BIT     = 1;
    localparam int BS_BIT      = 1;
    localparam int READ_DMA_POINTER_RESET_BIT  = 1;
    localparam int WPU_BIT     = 16;
    localparam int HD_DONE_BIT = 4;
    localparam int CD_DONE_BIT = 5;
    // ==============================
    // Reset value and address steps
    localparam logic [31:0] RST_WORD = 32'h0000_0000;
    localparam logic [31:0] DW_STEP  = 32'h0000_0004;
    localparam logic [31:0] QW_STEP  = 32'h0000_0008;
    // ==============================
    // Types
    typedef struct packed {
        logic        write;
        logic [31:0] addr;
        logic [31:0] wdata;
    } host_req_t;

    typedef enum logic [5:0] {
        V_IDLE = 6'b000001,
        V_SRD  = 6'b000010,
        V_PUSH = 6'b000100,
        V_VRD  = 6'b001000,
        V_WLO  = 6'b010000,
        V_WHI  = 6'b100000
    } vid_state_t;

    typedef enum logic [2:0] {
        C_IDLE    = 3'b001,
        C_FETCH   = 3'b010,
        C_DELIVER = 3'b100
    } cmd_state_t;
endpackage : dma_pkg

// [verif/host_mem_model.sv]
// Behavioural host memory answering the DMA unit's bus-master requests
`timescale 1ns/1ns
`default_nettype none
module host_mem_model (
    input  wire logic               pclk,
    input  wire logic               presetn,
    input  wire logic               host_req_valid,
    input  wire dma_pkg::host_req_t host_req,
    output logic                    host_ack,
    output logic [31:0]             host_rdata
);
    // ==============================
    // Answer alternates prompt and slow; read data is the address folded with a fixed pattern
    logic [2:0] wait_q;
    logic       slow_q;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wait_q     <= 3'h0;
            slow_q     <= 1'b0;
            host_ack   <= 1'b0;
            host_rdata <= 32'h0;
        end else begin
            host_ack   <= 1'b0;
            host_rdata <= ~host_rdata; // Data not held outside the answer cycle
            if (host_req_valid && !host_ack) begin
                wait_q <= wait_q + 3'h1;
                if (wait_q >= {slow_q, 2'h0}) begin
                    host_ack   <= 1'b1;
                    host_rdata <= host_req.addr ^ 32'h3c3c_0000;
                    wait_q     <= 3'h0;
                    slow_q     <= ~slow_q;
                end
            end
        end
    end
endmodule : host_mem_model
`default_nettype wire

// [verif/tb_top.sv]
// Self-checking bench for the two-channel bus-master DMA unit
`timescale 1ns/1ns
`default_nettype none
module tb_top;
    logic               pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [15:0]        paddr = 16'h0;
    logic [31:0]        pwdata = 32'h0, prdata, host_rdata, lpb_data, cmd_data, vmem_rd_addr;
    logic               pready, pslverr, host_req_valid, host_ack, lpb_valid, cmd_valid, vmem_rd_req;
    logic               lpb_ready = 1'b0, cmd_ready = 1'b0, vmem_rd_ack = 1'b0;
    logic [63:0]        vmem_rd_data = 64'h0;
    dma_pkg::host_req_t host_req;
    logic [31:0]        seed = 32'h0000_0044, sa, cb, r;
    logic [31:0]        lpb_q[$], cmd_q[$], wr_q[$], wa_q[$];
    int                 errors = 0, total_checks = 0;

    bus_master_dma u_bus_master_dma (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .host_req_valid(host_req_valid), .host_req(host_req), .host_ack(host_ack), .host_rdata(host_rdata),
        .lpb_valid(lpb_valid), .lpb_data(lpb_data), .lpb_ready(lpb_ready), .vmem_rd_req(vmem_rd_req),
        .vmem_rd_addr(vmem_rd_addr), .vmem_rd_ack(vmem_rd_ack), .vmem_rd_data(vmem_rd_data),
        .cmd_valid(cmd_valid), .cmd_data(cmd_data), .cmd_ready(cmd_ready));
    host_mem_model u_host_mem_model (.pclk(pclk), .presetn(presetn), .host_req_valid(host_req_valid),
        .host_req(host_req), .host_ack(host_ack), .host_rdata(host_rdata));

    // ==============================
    // Clock, random source, sinks that stall every other cycle, video memory answering
    always #50 pclk = ~pclk;
    function automatic logic [31:0] xs(input logic [31:0] s);
        s ^= s << 13;
        s ^= s >> 17;
        s ^= s << 5;
        return s;
    endfunction : xs
    always @(posedge pclk) begin
        lpb_ready    <= ~lpb_ready;
        cmd_ready    <= lpb_ready;
        vmem_rd_ack  <= vmem_rd_req & ~vmem_rd_ack;
        vmem_rd_data <= {~vmem_rd_addr, vmem_rd_addr};
    end

    // ==============================
    // Comparison, verdict and APB master
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            errors++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic print_verdict();
        $display("checks %0d errors %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : print_verdict
    task automatic apb(input logic wr, input logic [15:0] a, input logic [31:0] d);
        int n = 0;
        @(posedge pclk);
        psel <= 1'b1; pwrite <= wr; paddr <= a; pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin @(posedge pclk); n++; end while (pready !== 1'b1 && n < 20); // Answer sampled with request held
        if (n >= 20) begin errors++; print_verdict(); end
        r = pslverr ? 32'hffff_ffff : prdata;
        psel <= 1'b0; penable <= 1'b0;
    endtask : apb
    // Polls a register until the masked bits match; a run-out counts as a mismatch
    task automatic poll(input logic [15:0] a, input logic [31:0] m, input logic [31:0] w);
        int n = 0;
        do begin apb(1'b0, a, 32'h0); n++; end while ((r & m) !== w && n < 300);
        if (n >= 300) begin errors++; print_verdict(); end
    endtask : poll

    // ==============================
    // Monitor takes the oldest note whenever a word is handed over
    always @(posedge pclk) begin
        if (lpb_valid === 1'b1 && lpb_ready === 1'b1) check(lpb_data, lpb_q.pop_front());
        if (cmd_valid === 1'b1 && cmd_ready === 1'b1) check(cmd_data, cmd_q.pop_front());
        // Host writes only come from the video-memory direction
        if (host_req_valid === 1'b1 && host_ack === 1'b1 && host_req.write === 1'b1) begin
            check(host_req.wdata, wr_q.pop_front());
            check(host_req.addr, wa_q.pop_front());
        end
    end

    // ==============================
    // Main sequence: both channels at once, then 64K ring, then a disabled ring
    initial begin
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, 16'h0010, 32'h0);
        check(r, 32'hffff_ffff);
        seed = xs(seed);
        sa = seed & 32'hffff_fffc; // Direction 0, reserved bit 0 written as zero
        seed = xs(seed);
        cb = {seed[31:12], 12'h000};
        for (int i = 0; i < 3; i++) lpb_q.push_back((sa + 32'h4 * i) ^ 32'h3c3c_0000);
        for (int i = 0; i < 3; i++) cmd_q.push_back({cb[31:12], 10'h3fe + 10'(i), 2'h0} ^ 32'h3c3c_0000);
        apb(1'b1, dma_pkg::OFS_VID_START, sa);
        apb(1'b1, dma_pkg::OFS_VID_LEN, 32'h0000_0008);
        apb(1'b1, dma_pkg::OFS_CMD_BASE, cb);
        apb(1'b1, dma_pkg::OFS_CMD_RP, 32'h0000_0ff8);
        apb(1'b1, dma_pkg::OFS_CMD_WP, 32'h0001_0004);
        apb(1'b1, dma_pkg::OFS_VID_EN, 32'h1);
        apb(1'b1, dma_pkg::OFS_CMD_EN, 32'h1);
        poll(dma_pkg::OFS_VID_EN, 32'h1, 32'h0);
        check(r, 32'h0);
        poll(dma_pkg::OFS_CMD_RP, 32'hffff, 32'h4);
        check(r, 32'h4);
        apb(1'b0, dma_pkg::OFS_SUB_STAT, 32'h0);
        check(r & 32'h30, 32'h30);
        check(lpb_q.size() + cmd_q.size(), 32'h0);
        seed = xs(seed);
        cb = {seed[31:16], 16'h0002};
        cmd_q.push_back({cb[31:16], 16'hfffc} ^ 32'h3c3c_0000);
        cmd_q.push_back({cb[31:16], 16'h0000} ^ 32'h3c3c_0000);
        apb(1'b1, dma_pkg::OFS_CMD_BASE, cb);
        apb(1'b1, dma_pkg::OFS_CMD_RP, 32'h0000_fffc);
        poll(dma_pkg::OFS_CMD_RP, 32'hffff, 32'h4);
        check(cmd_q.size(), 32'h0);
        apb(1'b1, dma_pkg::OFS_CMD_EN, 32'h0);
        apb(1'b1, dma_pkg::OFS_CMD_WP, 32'h0001_0010);
        repeat (30) @(posedge pclk);
        apb(1'b0, dma_pkg::OFS_CMD_RP, 32'h0);
        check(r & 32'hffff, 32'h4);
        // Video memory to system memory: one qword per line, stride one qword, length kept at 3 dwords
        seed = xs(seed);
        cb = {seed[31:3], 3'h0};
        sa = {cb[31:4], 4'h2}; // Direction 1
        for (int i = 0; i < 3; i++) wa_q.push_back({cb[31:4], 4'h0} + 32'h4 * i);
        wr_q.push_back(cb);
        wr_q.push_back(~cb);
        wr_q.push_back(cb + 32'h10);
        apb(1'b1, dma_pkg::OFS_RD_BASE, cb);
        apb(1'b1, dma_pkg::OFS_RD_STRIDE, 32'h0000_0008);
        apb(1'b1, dma_pkg::OFS_ADV_CTRL, 32'h2);
        apb(1'b1, dma_pkg::OFS_ADV_CTRL, 32'h0);
        apb(1'b1, dma_pkg::OFS_VID_START, sa);
        apb(1'b1, dma_pkg::OFS_VID_EN, 32'h1);
        poll(dma_pkg::OFS_VID_EN, 32'h1, 32'h0);
        check(r, 32'h0);
        check(wr_q.size() + wa_q.size(), 32'h0);
        print_verdict();
    end
    // Guard against a hang anywhere
    initial begin
        #5000000;
        errors++;
        print_verdict();
    end
endmodule : tb_top
`default_nettype wire
